/* hdl/sbd_pkg.sv */
// Operation
// - Start with base address outside 0x0100..0x10FF sets the error flag.
// - Start with base valid but base plus count past window sets error flag.
// - Start with byte count above sixteen sets the error flag.
// - Accepted start clears error flag; software may clear it by writing zero.
// - Set error flag raises the serial port interrupt when enabled.
// - Failed start leaves address and byte-count registers unchanged.
// - Direction one copies RAM bytes into the empty transmit buffer.
// - Direction zero copies the earlier-filled receive buffer into RAM.
// - Software writes one to run bit; hardware clears it at the end.
// - Run bit stalls the CPU until the transfer finishes.
// - A running transfer cannot be interrupted or altered.
// - Address is 14 bits over high and low registers; top two bits read zero.
// - Reset address is 0x0100: high register 0x01, low register 0x00.
// - Address is source when transmitting, destination when receiving.
// - After a transfer the address holds last accessed address plus one.
// - Byte count in bits 4..0, bits 7..5 read zero, not cleared at end.
// - Engine starts only while the serial port is in buffer mode.
// - An N-byte transfer completes within N plus three cycles.
`default_nettype none
package sbd_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] REG_COUNT_IDX = 8'hDC;
    localparam logic [7:0] REG_ADDR_LOW_IDX = 8'hDD;
    localparam logic [7:0] REG_ADDR_HIGH_IDX = 8'hDE;
    localparam logic [7:0] REG_CTRL_IDX = 8'hDF;
    localparam logic [7:0] REG_INT_STATUS_IDX = 8'hE0;
    localparam logic [7:0] REG_INT_MASK_IDX = 8'hE1;
    // Control and status bit positions.
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_ERR_BIT = 2;
    // Interrupt status bit positions.
    localparam int INT_ERR_BIT = 0;
    localparam int INT_DONE_BIT = 1;
    // Address layout and permitted RAM window.
    localparam int ADDR_W = 14;
    localparam int COUNT_W = 5;
    localparam logic [ADDR_W-1:0] WINDOW_LOW = 14'h0100;
    localparam logic [ADDR_W:0] WINDOW_END = 15'h1100;
    // Reset values.
    localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0100;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 5'h00;
    localparam logic [1:0] INT_MASK_RESET = 2'h0;
    // Engine states, Gray coded along idle, check, move.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHECK = 2'b01,
        ST_MOVE = 2'b11
    } sbd_state_t;
endpackage
`default_nettype wire

/* hdl/sbd_serial_buffer_dma.sv */
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module sbd_serial_buffer_dma #(
    parameter int BUF_DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt and CPU stall.
    output logic irq_o,
    output logic cpu_stall_o,
    // Serial port status.
    input wire logic dual_port_mode_i,
    input wire logic [1:0] tx_buf_empty_i,
    input wire logic rx_buf_oldest_i,
    // RAM port.
    output logic [sbd_pkg::ADDR_W-1:0] ram_addr_o,
    output logic ram_rd_o,
    output logic ram_wr_o,
    output logic [7:0] ram_wdata_o,
    input wire logic [7:0] ram_rdata_i,
    // Dual-port buffer port.
    output logic buf_sel_o,
    output logic [$clog2(BUF_DEPTH)-1:0] buf_addr_o,
    output logic buf_rd_o,
    output logic buf_wr_o,
    output logic [7:0] buf_wdata_o,
    input wire logic [7:0] buf_rdata_i
);
    localparam int BA_W = $clog2(BUF_DEPTH);
    localparam int AW = sbd_pkg::ADDR_W;
    localparam int CW = sbd_pkg::COUNT_W;

    // The count field must hold the buffer size.
    if (BUF_DEPTH < 2 || BUF_DEPTH > 31) begin : g_depth_check
        $error("BUF_DEPTH must lie between 2 and 31");
    end

    sbd_pkg::sbd_state_t state_reg;
    logic [AW-1:0] addr_reg;
    logic [CW-1:0] count_reg;
    logic run_reg;
    logic dir_reg;
    logic err_reg;
    logic [1:0] int_status_reg;
    logic [1:0] int_mask_reg;
    logic [CW-1:0] rd_cnt_reg;
    logic [CW-1:0] wr_cnt_reg;
    logic fetch_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [7:0] reg_idx;
    logic bus_write;
    logic ctrl_write;
    logic start_bad;
    logic check_err;
    logic check_ok;
    logic move_done;
    logic [7:0] src_byte;
    logic start_go;
    logic rd_more;
    logic rd_issue;
    logic wr_step;
    logic [CW-1:0] rd_idx;

    // Checks the programmed window, span and count against the allowed area.
    function automatic logic range_bad(input logic [AW-1:0] base, input logic [CW-1:0] cnt);
        logic [AW:0] span_end;
        span_end = {1'b0, base} + {{(AW + 1 - CW){1'b0}}, cnt};
        range_bad = (base < sbd_pkg::WINDOW_LOW)
            || ({1'b0, base} >= sbd_pkg::WINDOW_END)
            || (span_end > sbd_pkg::WINDOW_END)
            || (cnt > CW'(BUF_DEPTH));
    endfunction

    // RAM address of byte k of the transfer, counted from the base.
    function automatic logic [AW-1:0] ram_at(input logic [AW-1:0] base, input logic [CW-1:0] k);
        ram_at = base + AW'(k);
    endfunction

    // Read value of one register index; unmapped indices read zero.
    function automatic logic [31:0] reg_read(input logic [7:0] idx);
        reg_read = 32'h0000_0000;
        unique case (idx)
            sbd_pkg::REG_COUNT_IDX: reg_read = {27'h0, count_reg};
            sbd_pkg::REG_ADDR_LOW_IDX: reg_read = {24'h0, addr_reg[7:0]};
            sbd_pkg::REG_ADDR_HIGH_IDX: reg_read = {26'h0, addr_reg[13:8]};
            sbd_pkg::REG_CTRL_IDX: reg_read = {29'h0, err_reg, dir_reg, run_reg};
            sbd_pkg::REG_INT_STATUS_IDX: reg_read = {30'h0, int_status_reg};
            sbd_pkg::REG_INT_MASK_IDX: reg_read = {30'h0, int_mask_reg};
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction

    // Bus decode: a write takes effect on the edge where ack is seen.
    assign reg_idx = wb_adr_i[9:2];
    assign bus_write = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
    assign ctrl_write = bus_write && reg_idx == sbd_pkg::REG_CTRL_IDX;
    assign start_bad = range_bad(addr_reg, count_reg);
    assign check_err = state_reg == sbd_pkg::ST_CHECK && start_bad;
    assign check_ok = state_reg == sbd_pkg::ST_CHECK && !start_bad;
    assign move_done = state_reg == sbd_pkg::ST_MOVE && wr_cnt_reg == count_reg && !fetch_reg;
    assign src_byte = dir_reg ? ram_rdata_i : buf_rdata_i;

    // Move control: a good start with a non-zero count issues byte zero at once.
    assign start_go = check_ok && count_reg != '0;
    assign rd_more = rd_cnt_reg != count_reg;
    assign rd_issue = start_go || (state_reg == sbd_pkg::ST_MOVE && rd_more);
    assign wr_step = state_reg == sbd_pkg::ST_MOVE && fetch_reg;
    assign rd_idx = start_go ? {CW{1'b0}} : rd_cnt_reg;

    // Wishbone ack: one wait state, dropped in the cycle after it was given.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
        end
    end

    // Read data is latched together with the ack; unmapped indices read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
            rdata_reg <= reg_read(reg_idx);
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Engine sequencing: check, then move, then back to idle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= sbd_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                sbd_pkg::ST_IDLE: begin
                    if (ctrl_write && wb_dat_i[sbd_pkg::CTRL_RUN_BIT] && dual_port_mode_i) begin
                        state_reg <= sbd_pkg::ST_CHECK;
                    end
                end
                sbd_pkg::ST_CHECK: begin
                    if (start_bad || count_reg == '0) begin
                        state_reg <= sbd_pkg::ST_IDLE;
                    end else begin
                        state_reg <= sbd_pkg::ST_MOVE;
                    end
                end
                sbd_pkg::ST_MOVE: begin
                    if (move_done) begin
                        state_reg <= sbd_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Run bit and CPU stall rise on the launching write and fall at the end.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg <= 1'b0;
            cpu_stall_o <= 1'b0;
        end else if (state_reg == sbd_pkg::ST_IDLE) begin
            if (ctrl_write && wb_dat_i[sbd_pkg::CTRL_RUN_BIT] && dual_port_mode_i) begin
                run_reg <= 1'b1;
                cpu_stall_o <= 1'b1;
            end
        end else if (check_err || (check_ok && count_reg == '0) || move_done) begin
            run_reg <= 1'b0;
            cpu_stall_o <= 1'b0;
        end
    end

    // Direction is written only while idle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_reg <= 1'b0;
        end else if (ctrl_write && state_reg == sbd_pkg::ST_IDLE) begin
            dir_reg <= wb_dat_i[sbd_pkg::CTRL_DIR_BIT];
        end
    end

    // Error flag: hardware set wins over a software clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_reg <= 1'b0;
        end else if (check_err) begin
            err_reg <= 1'b1;
        end else if (check_ok) begin
            err_reg <= 1'b0;
        end else if (ctrl_write && !wb_dat_i[sbd_pkg::CTRL_ERR_BIT]) begin
            err_reg <= 1'b0;
        end
    end

    // Address and count: software writes while idle; address advances on completion.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= sbd_pkg::ADDR_RESET;
            count_reg <= sbd_pkg::COUNT_RESET;
        end else if (move_done) begin
            addr_reg <= ram_at(addr_reg, count_reg);
        end else if (bus_write && state_reg == sbd_pkg::ST_IDLE) begin
            if (reg_idx == sbd_pkg::REG_ADDR_LOW_IDX) begin
                addr_reg[7:0] <= wb_dat_i[7:0];
            end
            if (reg_idx == sbd_pkg::REG_ADDR_HIGH_IDX) begin
                addr_reg[13:8] <= wb_dat_i[5:0];
            end
            if (reg_idx == sbd_pkg::REG_COUNT_IDX) begin
                count_reg <= wb_dat_i[CW-1:0];
            end
        end
    end

    // Read and write progress counters; reads run one per cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_cnt_reg <= '0;
            wr_cnt_reg <= '0;
        end else if (start_go) begin
            rd_cnt_reg <= CW'(1);
            wr_cnt_reg <= '0;
        end else if (state_reg == sbd_pkg::ST_MOVE) begin
            if (rd_more) begin
                rd_cnt_reg <= rd_cnt_reg + CW'(1);
            end
            if (fetch_reg) begin
                wr_cnt_reg <= wr_cnt_reg + CW'(1);
            end
        end
    end

    // The far side answers a read strobe one cycle later, so the byte stands now.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_reg <= 1'b0;
        end else begin
            fetch_reg <= ram_rd_o || buf_rd_o;
        end
    end

    // Buffer choice is taken at start: empty transmit or oldest receive buffer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_sel_o <= 1'b0;
        end else if (check_ok) begin
            buf_sel_o <= dir_reg ? !tx_buf_empty_i[0] : rx_buf_oldest_i;
        end
    end

    // Read strobes: RAM when transmitting, buffer when receiving.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ram_rd_o <= 1'b0;
            buf_rd_o <= 1'b0;
        end else begin
            ram_rd_o <= rd_issue && dir_reg;
            buf_rd_o <= rd_issue && !dir_reg;
        end
    end

    // Write strobes: one pulse for each byte that came back from the source.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ram_wr_o <= 1'b0;
            buf_wr_o <= 1'b0;
        end else begin
            buf_wr_o <= wr_step && dir_reg;
            ram_wr_o <= wr_step && !dir_reg;
        end
    end

    // RAM address: source of reads when transmitting, target of writes when receiving.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ram_addr_o <= sbd_pkg::ADDR_RESET;
        end else if (rd_issue && dir_reg) begin
            ram_addr_o <= ram_at(addr_reg, rd_idx);
        end else if (wr_step && !dir_reg) begin
            ram_addr_o <= ram_at(addr_reg, wr_cnt_reg);
        end
    end

    // Buffer address: read index when receiving, write index when transmitting.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_addr_o <= '0;
        end else if (rd_issue && !dir_reg) begin
            buf_addr_o <= BA_W'(rd_idx);
        end else if (wr_step && dir_reg) begin
            buf_addr_o <= BA_W'(wr_cnt_reg);
        end
    end

    // Buffer write data: the RAM byte that stands this cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_wdata_o <= 8'h00;
        end else if (wr_step && dir_reg) begin
            buf_wdata_o <= src_byte;
        end
    end

    // RAM write data: the buffer byte that stands this cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ram_wdata_o <= 8'h00;
        end else if (wr_step && !dir_reg) begin
            ram_wdata_o <= src_byte;
        end
    end

    // Sticky interrupt sources, write one to clear; a new event wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_status_reg <= 2'h0;
            int_mask_reg <= sbd_pkg::INT_MASK_RESET;
        end else begin
            if (bus_write && reg_idx == sbd_pkg::REG_INT_MASK_IDX) begin
                int_mask_reg <= wb_dat_i[1:0];
            end
            for (int i = 0; i < 2; i++) begin
                if (bus_write && reg_idx == sbd_pkg::REG_INT_STATUS_IDX && wb_dat_i[i]) begin
                    int_status_reg[i] <= 1'b0;
                end
            end
            if (check_err) begin
                int_status_reg[sbd_pkg::INT_ERR_BIT] <= 1'b1;
            end
            if (move_done || (check_ok && count_reg == '0)) begin
                int_status_reg[sbd_pkg::INT_DONE_BIT] <= 1'b1;
            end
        end
    end

    // Interrupt level: unmasked sticky bits, or the live error flag if enabled.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(int_status_reg & int_mask_reg)
                || (err_reg && int_mask_reg[sbd_pkg::INT_ERR_BIT]);
        end
    end
endmodule // sbd_serial_buffer_dma
`default_nettype wire

/* testbench/sbd_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Checks bus timing, stall span and move strobes at the engine's ports.
module sbd_props #(
    parameter int BUF_DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus and control.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic cpu_stall_o,
    input wire logic dual_port_mode_i,
    // Move strobes.
    input wire logic [sbd_pkg::ADDR_W-1:0] ram_addr_o,
    input wire logic ram_rd_o,
    input wire logic ram_wr_o,
    input wire logic buf_rd_o,
    input wire logic buf_wr_o,
    input wire logic [$clog2(BUF_DEPTH)-1:0] buf_addr_o
);
    // All checks share the system clock and its reset.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_wait_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o) else $error("ack late");
    stall_bound_a: assert property ($rose(cpu_stall_o) |-> ##[1:19] !cpu_stall_o)
        else $error("stall too long");
    mode_gate_a: assert property ($rose(cpu_stall_o) |-> $past(dual_port_mode_i))
        else $error("start without buffer mode");
    move_stalled_a: assert property ((ram_rd_o || ram_wr_o || buf_rd_o || buf_wr_o) |-> cpu_stall_o)
        else $error("move while idle");
    ram_window_a: assert property ((ram_rd_o || ram_wr_o) |-> ram_addr_o inside {[14'h0100:14'h10FF]})
        else $error("RAM access outside window");
    tx_pair_a: assert property (ram_rd_o |=> ##1 buf_wr_o) else $error("read not followed by buffer write");
    rx_pair_a: assert property (buf_rd_o |=> ##1 ram_wr_o) else $error("buffer read not stored");
    ram_step_a: assert property (ram_rd_o && $past(ram_rd_o) |-> ram_addr_o == $past(ram_addr_o) + 14'h1)
        else $error("RAM address skipped");
    buf_step_a: assert property (buf_wr_o && $past(buf_wr_o) |-> buf_addr_o == $past(buf_addr_o) + 1'b1)
        else $error("buffer address skipped");
endmodule // sbd_props
bind sbd_serial_buffer_dma sbd_props #(.BUF_DEPTH(BUF_DEPTH)) props_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .cpu_stall_o, .dual_port_mode_i, .ram_addr_o, .ram_rd_o, .ram_wr_o, .buf_rd_o, .buf_wr_o,
    .buf_addr_o);
`default_nettype wire

/* testbench/sbd_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// RAM and dual-port buffers on the far side of the engine.
module sbd_partner (
    // Clock.
    input wire logic clk_i,
    // RAM side.
    input wire logic [13:0] ram_addr_i,
    input wire logic ram_rd_i,
    input wire logic ram_wr_i,
    input wire logic [7:0] ram_wdata_i,
    output logic [7:0] ram_rdata_o,
    // Buffer side.
    input wire logic buf_sel_i,
    input wire logic [3:0] buf_addr_i,
    input wire logic buf_rd_i,
    input wire logic buf_wr_i,
    input wire logic [7:0] buf_wdata_i,
    output logic [7:0] buf_rdata_o
);
    logic [7:0] mem [0:16383];
    logic [7:0] txb [0:1][0:15];
    // RAM holds its own low address byte XORed with 0x5A.
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = i[7:0] ^ 8'h5A;
        end
        ram_rdata_o = 8'h00;
        buf_rdata_o = 8'h00;
    end
    // Reads answer a cycle later; idle lines toggle so stale data never matches.
    always @(posedge clk_i) begin
        ram_rdata_o <= ram_rd_i ? mem[ram_addr_i] : ~ram_rdata_o;
        buf_rdata_o <= buf_rd_i ? (8'hA0 | {3'h0, buf_sel_i, buf_addr_i}) : ~buf_rdata_o;
        if (ram_wr_i) begin
            mem[ram_addr_i] <= ram_wdata_i;
        end
        if (buf_wr_i) begin
            txb[buf_sel_i][buf_addr_i] <= buf_wdata_i;
        end
    end
endmodule // sbd_partner
`default_nettype wire

/* testbench/serial_buffer_dma_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_buffer_dma_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic dual_port_mode_i = 1'b1, rx_buf_oldest_i = 1'b1;
    logic [1:0] tx_buf_empty_i = 2'b10;
    logic wb_ack_o, irq_o, cpu_stall_o, ram_rd_o, ram_wr_o, buf_sel_o, buf_rd_o, buf_wr_o;
    logic [13:0] ram_addr_o;
    logic [7:0] ram_wdata_o, ram_rdata_i, buf_wdata_o, buf_rdata_i;
    logic [3:0] buf_addr_o;
    int n_mismatch = 0;
    int total_checks = 0;
    // The clock toggles every half period of 25 ns.
    always #25 clk_i = ~clk_i;
    sbd_serial_buffer_dma #(.BUF_DEPTH(16)) dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .cpu_stall_o, .dual_port_mode_i,
        .tx_buf_empty_i, .rx_buf_oldest_i, .ram_addr_o, .ram_rd_o, .ram_wr_o, .ram_wdata_o, .ram_rdata_i,
        .buf_sel_o, .buf_addr_o, .buf_rd_o, .buf_wr_o, .buf_wdata_o, .buf_rdata_i);
    sbd_partner p_u (.clk_i(clk_i), .ram_addr_i(ram_addr_o), .ram_rd_i(ram_rd_o), .ram_wr_i(ram_wr_o),
        .ram_wdata_i(ram_wdata_o), .ram_rdata_o(ram_rdata_i), .buf_sel_i(buf_sel_o), .buf_addr_i(buf_addr_o),
        .buf_rd_i(buf_rd_o), .buf_wr_i(buf_wr_o), .buf_wdata_i(buf_wdata_o), .buf_rdata_o(buf_rdata_i));
    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle, held until ack is sampled high.
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, idx, 8'h00, q);
        chk(q, exp);
    endtask
    // Writes the control register and waits until the stall ends.
    task automatic go(input logic [7:0] v);
        int n;
        n = 0;
        wr(8'hDF, v);
        @(posedge clk_i);
        while (cpu_stall_o !== 1'b0 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        if (cpu_stall_o !== 1'b0) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic irq_is(input logic [7:0] exp);
        repeat (2) @(posedge clk_i);
        chk({7'h0, irq_o}, exp);
    endtask
    // Main sequence of register scenarios.
    initial begin
        logic [13:0] base [5];
        logic [7:0] cnt [5];
        logic [13:0] ea;
        logic bad;
        base = '{14'h00FF, 14'h1100, 14'h10F8, 14'h0100, 14'h10F0};
        cnt = '{8'h01, 8'h01, 8'h10, 8'h11, 8'h10};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'hDD, 8'h00);
        rd(8'hDE, 8'h01);
        rd(8'hDC, 8'h00);
        rd(8'hE1, 8'h00);
        wr(8'h10, 8'h5C);
        rd(8'h10, 8'h00);
        wr(8'hDE, 8'hFF);
        rd(8'hDE, 8'h3F);
        wr(8'hDC, 8'hFF);
        rd(8'hDC, 8'h1F);
        wr(8'hDE, 8'h01);
        // Three bytes go to the empty second transmit buffer.
        wr(8'hDC, 8'h03);
        go(8'h03);
        rd(8'hDF, 8'h02);
        rd(8'hDD, 8'h03);
        rd(8'hDC, 8'h03);
        for (int k = 0; k < 3; k++) begin
            chk(p_u.txb[1][k], k[7:0] ^ 8'h5A);
        end
        // Two bytes come from the older receive buffer, right behind.
        wr(8'hDC, 8'h02);
        go(8'h01);
        rd(8'hDD, 8'h05);
        for (int k = 0; k < 2; k++) begin
            chk(p_u.mem[14'h0103 + k], 8'hB0 | k[7:0]);
        end
        // A zero count reports done; the mask gates the line.
        wr(8'hDC, 8'h00);
        go(8'h01);
        irq_is(8'h00);
        rd(8'hE0, 8'h02);
        wr(8'hE1, 8'h02);
        irq_is(8'h01);
        wr(8'hE0, 8'h02);
        irq_is(8'h00);
        // Four refused starts, then one that ends exactly at the top of the window.
        wr(8'hE1, 8'h01);
        for (int i = 0; i < 5; i++) begin
            bad = (i < 4);
            ea = bad ? base[i] : base[i] + {6'h0, cnt[i]};
            wr(8'hDD, base[i][7:0]);
            wr(8'hDE, {2'h0, base[i][13:8]});
            wr(8'hDC, cnt[i]);
            go(8'h03);
            rd(8'hDF, bad ? 8'h06 : 8'h02);
            rd(8'hDD, ea[7:0]);
            rd(8'hDE, {2'h0, ea[13:8]});
            rd(8'hDC, cnt[i]);
            irq_is({7'h0, bad});
            if (i != 3) begin
                wr(8'hDF, 8'h02);
                rd(8'hDF, 8'h02);
            end
            wr(8'hE0, 8'h03);
            irq_is({7'h0, i == 3});
        end
        chk(p_u.txb[1][15], 8'hA5);
        // Without buffer mode a start is ignored.
        wr(8'hDE, 8'h01);
        dual_port_mode_i <= 1'b0;
        go(8'h01);
        rd(8'hDF, 8'h00);
        rd(8'hDD, 8'h00);
        conclude();
    end
endmodule // serial_buffer_dma_tb
`default_nettype wire
